// ===== logic/coupler_params.svh
// Constants of the coupler sample read port: offsets, fields, reset values and codes.
// How it works
// - Displacement sample returns first-char displacement low byte, present-char high byte.
// - Status-word sample returns the processor-written status on low 12 bits except bit 8.
// - Status-word bit 8 carries the top bit of the 17-bit present address.
// - Coupler-status sample returns the current internal condition flags.
// - Coupler-status read clears non-alarm conditions but keeps order-word-loaded pending.
// - Order-word sample returns the order word register on low 12 bits.
// - Order-word read clears the loaded flag; the order-loaded interrupt status bit stays set until written one.
// - Respond only to equipment address 1100 or 1101.
// - Command bit 3 zero means sample, one means set; a sample also needs bit 2 zero.
// - Peripheral order word loads register, sets loaded flag, raises interrupt.
// - Hold empty acknowledge while the previous order word is unread.
`ifndef COUPLER_PARAMS_SVH
`define COUPLER_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets on the APB side
// ----------------------------------------------------------------
`define CSP_OFF_CMD 8'h00
`define CSP_OFF_DATA 8'h04
`define CSP_OFF_FLAGS 8'h08
`define CSP_OFF_IRQ_STAT 8'h0C
`define CSP_OFF_IRQ_MASK 8'h10
`define CSP_OFF_LAST_CMD 8'h14

// ----------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------
`define CSP_CMD_ZERO_HI 15
`define CSP_CMD_ZERO_LO 11
`define CSP_CMD_EQ_HI 10
`define CSP_CMD_EQ_LO 7
`define CSP_CMD_FN_HI 6
`define CSP_CMD_FN_LO 4
`define CSP_CMD_DIR_BIT 3
`define CSP_CMD_AUX_BIT 2
`define CSP_EQ_FIRST 4'hC
`define CSP_EQ_SECOND 4'hD

// ----------------------------------------------------------------
// Sample function codes (bits 6..4 with bits 3..2 zero)
// ----------------------------------------------------------------
`define CSP_FN_MA_ZERO 3'h0
`define CSP_FN_MA 3'h1
`define CSP_FN_DISP 3'h3
`define CSP_FN_PROC_STATUS 3'h4
`define CSP_FN_CPL_STATUS 3'h5
`define CSP_FN_ORDER 3'h6

// ----------------------------------------------------------------
// Flag positions and reset values
// ----------------------------------------------------------------
`define CSP_ORDER_LOADED_BIT 4
`define CSP_STATUS_MSB_BIT 8
`define CSP_ALARM_MASK 16'h0003
`define CSP_IRQ_ORDER_LOADED 0
`define CSP_IRQ_SAMPLE_DONE 1
`define CSP_IRQ_IGNORED 2
`define CSP_IRQ_CONDITION 3
`define CSP_IRQ_RESET 4'h0
`define CSP_MASK_RESET 4'h0
`define CSP_CMD_RESET 16'h0000

`endif

// ===== logic/coupler_pkg.sv
// Types shared by the coupler sample read port.
package coupler_pkg;

    // ----------------------------------------------------------------
    // APB answer phase
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {
        APB_IDLE = 1'b0,
        APB_ANSWER = 1'b1
    } apb_phase_t;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [11:0] word;
    } order_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } sample_out_t;

    typedef struct packed {
        logic [7:0] first_char_displacement;
        logic [7:0] present_char_displacement;
        logic [11:0] proc_status;
        logic [16:0] present_addr;
    } coupler_view_t;

    // ----------------------------------------------------------------
    // Whole state of the block
    // ----------------------------------------------------------------
    typedef struct packed {
        apb_phase_t phase;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [15:0] last_cmd;
        sample_out_t sample;
        logic [15:0] cond;
        logic order_word_loaded_flag;
        logic [11:0] order_word;
        logic order_ack;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic irq;
        logic proc_int;
    } state_t;

endpackage : coupler_pkg

// ===== logic/coupler_sample_read_port.sv
// Sample (read) side of the coupler command port with an APB register front end.
//
// The placing of the registers and the APB register port were decided locally.
`include "coupler_params.svh"

module coupler_sample_read_port #(
    parameter logic [15:0] ALARM_MASK = `CSP_ALARM_MASK
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire coupler_pkg::coupler_view_t view,
    input wire logic [15:0] cond_event,
    input wire coupler_pkg::order_req_t order_req,
    output logic order_ack,
    output coupler_pkg::sample_out_t sample,
    output logic proc_int,
    output logic irq
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------

    // True when the command addresses this coupler.
    function automatic logic eq_match(input logic [15:0] cmd);
        logic ok;
        ok = (cmd[`CSP_CMD_ZERO_HI:`CSP_CMD_ZERO_LO] == 5'h00);
        return ok && ((cmd[`CSP_CMD_EQ_HI:`CSP_CMD_EQ_LO] == `CSP_EQ_FIRST)
            || (cmd[`CSP_CMD_EQ_HI:`CSP_CMD_EQ_LO] == `CSP_EQ_SECOND));
    endfunction : eq_match

    // Coupler condition flags as software sees them.
    function automatic logic [15:0] flag_view(input logic [15:0] cond, input logic loaded);
        logic [15:0] f;
        f = cond;
        f[`CSP_ORDER_LOADED_BIT] = loaded;
        return f;
    endfunction : flag_view

    coupler_pkg::state_t st_q;
    coupler_pkg::state_t st_d;

    logic access;
    logic done;
    logic wr_done;
    logic mapped;
    logic cmd_issue;
    logic cmd_hit;
    logic is_sample;
    logic [2:0] fn;
    logic [15:0] cmd;
    logic [15:0] rd_word;
    logic [15:0] cond_in;
    logic [15:0] flags_now;
    logic [3:0] irq_evt;
    logic order_take;
    logic order_read;
    logic status_read;

    always_comb begin
        st_d = st_q;
        access = psel && penable;
        done = access && st_q.pready;
        wr_done = done && pwrite;
        mapped = (paddr == `CSP_OFF_CMD) || (paddr == `CSP_OFF_DATA)
            || (paddr == `CSP_OFF_FLAGS) || (paddr == `CSP_OFF_IRQ_STAT)
            || (paddr == `CSP_OFF_IRQ_MASK) || (paddr == `CSP_OFF_LAST_CMD);
        cmd = pwdata[15:0];
        fn = cmd[`CSP_CMD_FN_HI:`CSP_CMD_FN_LO];
        cmd_issue = wr_done && (paddr == `CSP_OFF_CMD);
        cmd_hit = cmd_issue && eq_match(cmd);
        is_sample = !cmd[`CSP_CMD_DIR_BIT] && !cmd[`CSP_CMD_AUX_BIT];
        cond_in = cond_event & ~(16'h0001 << `CSP_ORDER_LOADED_BIT);
        flags_now = flag_view(st_q.cond, st_q.order_word_loaded_flag);
        status_read = 1'b0;
        order_read = 1'b0;
        rd_word = 16'h0000;

        // ----------------------------------------------------------------
        // Sample command decode
        // ----------------------------------------------------------------
        if (cmd_hit && is_sample) begin
            case (fn)
                `CSP_FN_MA_ZERO: begin
                    rd_word[8:0] = view.present_addr[16:8];
                end
                `CSP_FN_MA: begin
                    rd_word = view.present_addr[15:0];
                end
                `CSP_FN_DISP: begin
                    rd_word = {view.present_char_displacement,
                        view.first_char_displacement};
                end
                `CSP_FN_PROC_STATUS: begin
                    rd_word[11:0] = view.proc_status;
                    rd_word[`CSP_STATUS_MSB_BIT] = view.present_addr[16];
                end
                `CSP_FN_CPL_STATUS: begin
                    rd_word = flags_now;
                    status_read = 1'b1;
                end
                `CSP_FN_ORDER: begin
                    rd_word[11:0] = st_q.order_word;
                    order_read = 1'b1;
                end
                default: begin
                    rd_word = 16'h0000;
                end
            endcase
        end

        // ----------------------------------------------------------------
        // Sample result and last command
        // ----------------------------------------------------------------
        st_d.sample.valid = 1'b0;
        if (cmd_issue) begin
            st_d.last_cmd = cmd;
        end
        if (cmd_hit && is_sample) begin
            st_d.sample.valid = 1'b1;
            st_d.sample.data = rd_word;
        end

        // ----------------------------------------------------------------
        // Coupler conditions; a new event wins over the read clear
        // ----------------------------------------------------------------
        if (status_read) begin
            st_d.cond = (st_q.cond & ALARM_MASK) | cond_in;
        end else begin
            st_d.cond = st_q.cond | cond_in;
        end

        // ----------------------------------------------------------------
        // Order word from the peripheral processor
        // ----------------------------------------------------------------
        order_take = order_req.valid && !st_q.order_word_loaded_flag
            && !st_q.order_ack;
        st_d.order_ack = order_take;
        if (order_take) begin
            st_d.order_word = order_req.word;
            st_d.order_word_loaded_flag = 1'b1;
        end else if (order_read) begin
            st_d.order_word_loaded_flag = 1'b0;
        end
        st_d.proc_int = |flag_view(st_d.cond, st_d.order_word_loaded_flag);

        // ----------------------------------------------------------------
        // Interrupt status, mask and line
        // ----------------------------------------------------------------
        irq_evt = 4'h0;
        irq_evt[`CSP_IRQ_ORDER_LOADED] = order_take;
        irq_evt[`CSP_IRQ_SAMPLE_DONE] = cmd_hit && is_sample;
        irq_evt[`CSP_IRQ_IGNORED] = cmd_issue && !(cmd_hit && is_sample);
        irq_evt[`CSP_IRQ_CONDITION] = |cond_in;
        st_d.irq_stat = st_q.irq_stat | irq_evt;
        if (wr_done && (paddr == `CSP_OFF_IRQ_STAT)) begin
            st_d.irq_stat = (st_q.irq_stat & ~pwdata[3:0]) | irq_evt;
        end
        if (wr_done && (paddr == `CSP_OFF_IRQ_MASK)) begin
            st_d.irq_mask = pwdata[3:0];
        end
        st_d.irq = |(st_d.irq_stat & st_d.irq_mask);

        // ----------------------------------------------------------------
        // APB slave: one wait state, then pready for one cycle
        // ----------------------------------------------------------------
        case (st_q.phase)
            coupler_pkg::APB_IDLE: begin
                st_d.pready = 1'b0;
                st_d.pslverr = 1'b0;
                if (access) begin
                    st_d.phase = coupler_pkg::APB_ANSWER;
                    st_d.pready = 1'b1;
                    st_d.pslverr = !mapped;
                    st_d.prdata = 32'h0000_0000;
                    if (!pwrite) begin
                        case (paddr)
                            `CSP_OFF_DATA: st_d.prdata = {16'h0000, st_q.sample.data};
                            `CSP_OFF_FLAGS: st_d.prdata = {16'h0000, flags_now};
                            `CSP_OFF_IRQ_STAT: st_d.prdata = {28'h0000000, st_q.irq_stat};
                            `CSP_OFF_IRQ_MASK: st_d.prdata = {28'h0000000, st_q.irq_mask};
                            `CSP_OFF_LAST_CMD: st_d.prdata = {16'h0000, st_q.last_cmd};
                            default: st_d.prdata = 32'h0000_0000;
                        endcase
                    end
                end
            end
            coupler_pkg::APB_ANSWER: begin
                st_d.phase = coupler_pkg::APB_IDLE;
                st_d.pready = 1'b0;
                st_d.pslverr = 1'b0;
            end
            default: begin
                st_d.phase = coupler_pkg::APB_IDLE;
                st_d.pready = 1'b0;
                st_d.pslverr = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q <= '0;
            st_q.phase <= coupler_pkg::APB_IDLE;
            st_q.last_cmd <= `CSP_CMD_RESET;
            st_q.irq_stat <= `CSP_IRQ_RESET;
            st_q.irq_mask <= `CSP_MASK_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign order_ack = st_q.order_ack;
    assign sample = st_q.sample;
    assign proc_int = st_q.proc_int;
    assign irq = st_q.irq;

endmodule : coupler_sample_read_port

// ===== verif/coupler_sample_read_port_checker.sv
// Port assertions for the coupler sample read port.
module coupler_sample_read_port_checker #(
    parameter logic [15:0] ALARM_MASK = 16'h0003
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire coupler_pkg::coupler_view_t view,
    input wire logic [15:0] cond_event,
    input wire coupler_pkg::order_req_t order_req,
    input wire logic order_ack,
    input wire coupler_pkg::sample_out_t sample,
    input wire logic proc_int,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cmd_q;
    logic [11:0] word_q;
    logic [11:0] ow_q;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // Keeps the last command word issued and the last order word taken.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cmd_q <= 16'h0000;
            word_q <= 12'h000;
            ow_q <= 12'h000;
        end else begin
            if (psel && penable && pready && pwrite && paddr == 8'h00) begin
                cmd_q <= pwdata[15:0];
            end
            word_q <= order_req.word;
            if (order_ack) begin
                ow_q <= word_q;
            end
        end
    end
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
    property p_one_wait; psel && penable && !$past(penable) |=> pready; endproperty
    a_one_wait: assert property (p_one_wait) else $error("pready not in second access cycle");
    property p_ack_flag; order_ack |-> proc_int; endproperty
    a_ack_flag: assert property (p_ack_flag) else $error("order taken without flag");
    property p_ack_req; order_ack |-> $past(order_req.valid) ##1 !order_ack; endproperty
    a_ack_req: assert property (p_ack_req) else $error("acknowledge without order word");
    property p_disp;
        sample.valid && cmd_q[6:0] == 7'h30 |-> sample.data ==
            {$past(view.present_char_displacement), $past(view.first_char_displacement)};
    endproperty
    a_disp: assert property (p_disp) else $error("displacement sample wrong");
    property p_status;
        sample.valid && cmd_q[6:0] == 7'h40 |-> sample.data == {4'h0,
            $past(view.proc_status[11:9]), $past(view.present_addr[16]),
            $past(view.proc_status[7:0])};
    endproperty
    a_status: assert property (p_status) else $error("status sample wrong");
    property p_order; sample.valid && cmd_q[6:0] == 7'h60 |-> sample.data == {4'h0, ow_q}; endproperty
    a_order: assert property (p_order) else $error("order word sample wrong");
    property p_addr;
        sample.valid |-> cmd_q[10:7] inside {4'hC, 4'hD} && !cmd_q[3] && cmd_q[15:11] == 5'h00;
    endproperty
    a_addr: assert property (p_addr) else $error("sample on foreign command");
endmodule : coupler_sample_read_port_checker

// ===== verif/peripheral_model.sv
// Peripheral processor model that hands order words to the coupler.
module peripheral_model (
    input wire logic ref_clk,
    input wire logic order_ack,
    output coupler_pkg::order_req_t order_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] q[$];
    initial begin
        order_req = '0;
        forever begin
            @(posedge ref_clk);
            if (q.size() != 0 && !order_req.valid) begin
                order_req <= {1'b1, q.pop_front()};
            end else if (order_ack) begin
                order_req <= {1'b0, ~order_req.word};
            end
        end
    end
endmodule : peripheral_model

// ===== verif/coupler_sample_read_port_test.sv
// Self-checking bench for the coupler sample read port.
`include "coupler_params.svh"
module coupler_sample_read_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    coupler_pkg::coupler_view_t view = '0;
    logic [15:0] cond_event = 16'h0000;
    coupler_pkg::order_req_t order_req;
    coupler_pkg::sample_out_t sample;
    logic order_ack;
    logic proc_int;
    logic irq;
    logic [31:0] rd;
    logic err;
    int n_fail = 0;
    int tests_run = 0;
    int cyc = 0;
    int n_ack = 0;
    always #5 ref_clk = ~ref_clk;
    coupler_sample_read_port u_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .view(view), .cond_event(cond_event), .order_req(order_req),
        .order_ack(order_ack), .sample(sample), .proc_int(proc_int), .irq(irq));
    peripheral_model u_periph (.ref_clk(ref_clk), .order_ack(order_ack), .order_req(order_req));
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (order_ack === 1'b1) begin
            n_ack <= n_ack + 1;
        end
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : bus
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rchk
    task automatic cmd(input logic [15:0] c);
        bus(1'b1, `CSP_OFF_CMD, {16'h0000, c});
    endtask : cmd
    task automatic wait_ack(input int n);
        while (n_ack < n) @(posedge ref_clk);
    endtask : wait_ack
    task automatic t_reset;
        rchk(`CSP_OFF_IRQ_MASK, 32'h0);
        rchk(`CSP_OFF_IRQ_STAT, 32'h0);
        rchk(`CSP_OFF_FLAGS, 32'h0);
        rchk(8'h18, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk({31'h0, proc_int}, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("reset test done");
    endtask : t_reset
    task automatic t_disp;
        view.first_char_displacement <= 8'h3C;
        view.present_char_displacement <= 8'hA7;
        cmd(16'h0630);
        rchk(`CSP_OFF_DATA, 32'h0000A73C);
        view.first_char_displacement <= 8'h5A;
        cmd(16'h06B0);
        rchk(`CSP_OFF_DATA, 32'h0000A75A);
        $display("displacement test done");
    endtask : t_disp
    task automatic t_status;
        view.proc_status <= 12'h2F1;
        view.present_addr <= 17'h10000;
        cmd(16'h0640);
        rchk(`CSP_OFF_DATA, 32'h000003F1);
        view.proc_status <= 12'hFFF;
        view.present_addr <= 17'h0FFFF;
        cmd(16'h0640);
        rchk(`CSP_OFF_DATA, 32'h00000EFF);
        cmd(16'h0600);
        rchk(`CSP_OFF_DATA, 32'h000000FF);
        cmd(16'h0610);
        rchk(`CSP_OFF_DATA, 32'h0000FFFF);
        cmd(16'h0670);
        rchk(`CSP_OFF_DATA, 32'h00000000);
        $display("status test done");
    endtask : t_status
    task automatic t_order;
        cond_event <= 16'h0005;
        @(posedge ref_clk);
        cond_event <= 16'h0000;
        u_periph.q.push_back(12'h5C3);
        u_periph.q.push_back(12'h2A9);
        wait_ack(1);
        rchk(`CSP_OFF_FLAGS, 32'h15);
        chk({31'h0, proc_int}, 32'h1);
        cmd(16'h0650);
        rchk(`CSP_OFF_DATA, 32'h15);
        rchk(`CSP_OFF_FLAGS, 32'h11);
        chk(32'(n_ack), 32'h1);
        cmd(16'h0660);
        rchk(`CSP_OFF_DATA, 32'h5C3);
        wait_ack(2);
        rchk(`CSP_OFF_FLAGS, 32'h11);
        cmd(16'h0660);
        rchk(`CSP_OFF_DATA, 32'h2A9);
        rchk(`CSP_OFF_FLAGS, 32'h01);
        $display("order word test done");
    endtask : t_order
    task automatic t_ignore;
        bus(1'b1, `CSP_OFF_IRQ_STAT, 32'hF);
        bus(1'b1, `CSP_OFF_IRQ_MASK, 32'h4);
        rchk(`CSP_OFF_IRQ_STAT, 32'h0);
        chk({31'h0, irq}, 32'h0);
        cmd(16'h0730);
        cmd(16'h0638);
        rchk(`CSP_OFF_LAST_CMD, 32'h0638);
        rchk(`CSP_OFF_DATA, 32'h2A9);
        rchk(`CSP_OFF_IRQ_STAT, 32'h4);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, `CSP_OFF_IRQ_MASK, 32'h0);
        rchk(`CSP_OFF_IRQ_MASK, 32'h0);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, `CSP_OFF_IRQ_MASK, 32'h4);
        bus(1'b1, `CSP_OFF_IRQ_STAT, 32'h4);
        rchk(`CSP_OFF_IRQ_STAT, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("ignore and interrupt test done");
    endtask : t_ignore
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_disp();
        t_status();
        t_order();
        t_ignore();
        complete_run();
    end
endmodule : coupler_sample_read_port_test
bind coupler_sample_read_port coupler_sample_read_port_checker #(.ALARM_MASK(ALARM_MASK)) u_chk (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .view(view), .cond_event(cond_event), .order_req(order_req), .order_ack(order_ack),
    .sample(sample), .proc_int(proc_int), .irq(irq));
